/* File: bench/regi2c_chk.sv */
// assertions and covers on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module regi2c_chk (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic sda_q;
  logic scl_q;
  logic seen_r;
  logic [7:0] per_r;
  logic [3:0] bit_r;
  logic [3:0] warm_r;
  wire start_w = scl && scl_q && sda_q && !sda;
  // bus samplers, start seen flag, cycles since scl fall, scl rises since start, settle time after reset
  always_ff @(posedge I_CLK) begin
    sda_q <= sda;
    scl_q <= scl;
    if (I_RST) begin
      seen_r <= 1'b0;
      per_r <= 8'hff;
      bit_r <= 4'hf;
      warm_r <= 4'hf;
    end else begin
      seen_r <= seen_r | start_w;
      warm_r <= (warm_r == 4'h0) ? warm_r : warm_r - 4'h1;
      per_r <= (scl_q && !scl) ? 8'h00 : ((per_r == 8'hff) ? per_r : per_r + 8'h01);
      bit_r <= start_w ? 4'h0 : ((!scl_q && scl && bit_r != 4'hf) ? bit_r + 4'h1 : bit_r);
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  // the link side leaves reset a few link cycles after I_RST falls
  default disable iff (I_RST || warm_r != 4'h0);
  AST_OD_ONLY: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("target drove sda high");
  AST_CHG_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target changed sda while scl high");
  AST_AFTER_START: assert property ($rose(dev_sda_oe) |-> seen_r)
    else $error("target drove sda before any start");
  AST_ACK_HOLD: assert property ($rose(scl) && dev_sda_oe |=> dev_sda_oe [*8])
    else $error("target let go of sda during scl high");
  AST_ACK_NINTH: assert property (!scl_q && scl && dev_sda_oe && bit_r < 4'h9 |-> bit_r == 4'h8)
    else $error("address ack not on ninth clock");
  AST_SCL_RATE: assert property (scl_q && !scl |-> per_r >= 8'h27)
    else $error("scl period below one microsecond");
  AST_SCL_HIGH: assert property ($rose(scl) |=> scl [*8])
    else $error("scl high pulse too short");
  AST_STOP_QUIET: assert property (scl && $rose(sda) |=> !dev_sda_oe [*8])
    else $error("target drove sda after stop");
  cover property (start_w);
  cover property (!scl_q && scl && dev_sda_oe && bit_r == 4'h8);
  cover property (scl && $rose(sda));
endmodule
`default_nettype wire

/* File: bench/tb_i2c_register_access_slave.sv */
// two-ended bench: host and target joined on one bus
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_register_access_slave;
  import regi2c_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic link_clk = 1'b0;
  logic go = 1'b0;
  logic rd = 1'b0;
  logic use_ptr = 1'b0;
  logic shdn = 1'b0;
  logic busy, done, fail, wtake, rvalid, reg_wr, reg_rd, active, lock;
  logic [6:0] dev_addr = 7'h38;
  logic [7:0] len = 8'h01;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, reg_wdata;
  logic [7:0] mem [256];
  logic [7:0] ex [256];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  ptr_t ptr = PTR_BASE;
  ptr_t reg_addr;
  strap_t strap = STRAP_VDD;
  int err_count = 0;
  int total_checks = 0;
  initial forever #12.5 I_CLK = ~I_CLK;
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  twi_if bus ();
  twi_host twi_host_inst (.I_CLK(I_CLK), .I_RST(I_RST), .I_GO(go), .I_RD(rd), .I_USE_PTR(use_ptr),
    .I_DEV_ADDR(dev_addr), .I_PTR(ptr), .I_LEN(len), .I_WDATA(wdata), .O_WD_TAKE(wtake),
    .O_RD_VALID(rvalid), .O_RDATA(rdata), .O_BUSY(busy), .O_DONE(done), .O_FAIL(fail), .TWI(bus));
  twi_target twi_target_inst (.I_CLK(I_CLK), .I_RST(I_RST), .I_LINK_CLK(link_clk), .I_ADDR_STRAP(strap),
    .I_ADDR_LOCKED(lock), .I_SW_SHDN(shdn), .I_REG_RDATA(mem[reg_addr[7:0]]), .O_REG_WR(reg_wr),
    .O_REG_RD(reg_rd), .O_REG_ADDR(reg_addr), .O_REG_WDATA(reg_wdata), .O_ACTIVE(active), .TWI(bus));
  regi2c_chk regi2c_chk_inst (.I_CLK(I_CLK), .I_RST(I_RST), .scl(bus.scl), .sda(bus.sda),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));
  // register file model: one locked field at 0x200f
  assign lock = (reg_addr == 16'h200f);
  always @(posedge I_CLK) if (reg_wr) mem[reg_addr[7:0]] <= reg_wdata;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input strap_t s);
    strap = s;
    I_RST = 1'b1;
    repeat (6) @(posedge I_CLK);
    #1;
    I_RST = 1'b0;
    repeat (20) @(posedge I_CLK);
    #1;
  endtask
  // one host frame; write bytes come from wq, read bytes land in rq
  task automatic frame(input logic r, input logic p, input logic [6:0] a, input ptr_t at, input int n,
      input logic exp_fail);
    int i;
    int k;
    int nrd;
    logic seen;
    rd = r;
    nrd = 0;
    seen = 1'b0;
    use_ptr = p;
    dev_addr = a;
    ptr = at;
    len = n[7:0];
    rq = {};
    i = 0;
    if (wq.size() > 0) wdata = wq[0];
    go = 1'b1;
    @(posedge I_CLK);
    #1;
    go = 1'b0;
    for (k = 0; k < 30000 && done !== 1'b1; k++) begin
      if (wtake === 1'b1 && i + 1 < wq.size()) begin
        i++;
        wdata = wq[i];
      end
      if (rvalid === 1'b1) rq.push_back(rdata);
      if (active === 1'b1) seen = 1'b1;
      if (reg_rd === 1'b1) nrd++;
      @(posedge I_CLK);
      #1;
    end
    chk({7'h0, done}, 8'h01);
    chk({7'h0, fail}, {7'h0, exp_fail});
    chk({7'h0, busy}, 8'h00);
    chk({7'h0, seen}, {7'h0, strap < STRAP_OPEN});
    chk(8'(nrd), r ? 8'(n + 1) : 8'h00);
    repeat (40) @(posedge I_CLK);
    #1;
  endtask
  task automatic cmp(input int b, input int n);
    for (int j = 0; j < n; j++) chk(mem[b + j], ex[b + j]);
  endtask
  task automatic rchk(input int b, input int n);
    chk(8'(rq.size()), 8'(n));
    for (int j = 0; j < n; j++) chk(rq[j], ex[b + j]);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    for (int j = 0; j < 256; j++) begin
      mem[j] = 8'(j) ^ 8'ha5;
      ex[j] = 8'(j) ^ 8'ha5;
    end
    do_reset(STRAP_VDD);
    chk({7'h0, active}, 8'h00);
    wq = {8'h11, 8'h22, 8'h33};
    frame(1'b0, 1'b0, 7'h38, 16'h2010, 3, 1'b0);
    ex[16] = 8'h11;
    ex[17] = 8'h22;
    ex[18] = 8'h33;
    cmp(16, 3);
    frame(1'b1, 1'b1, 7'h38, 16'h2011, 2, 1'b0);
    rchk(17, 2);
    frame(1'b1, 1'b0, 7'h38, 16'h2011, 2, 1'b0);
    rchk(0, 2);
    frame(1'b1, 1'b0, 7'h38, 16'h2011, 1, 1'b0);
    rchk(0, 1);
    wq = {8'h44};
    frame(1'b0, 1'b0, 7'h39, 16'h2020, 1, 1'b1);
    cmp(32, 1);
    wq = {8'h55, 8'h66};
    frame(1'b0, 1'b0, 7'h38, 16'h200e, 2, 1'b0);
    ex[14] = 8'h55;
    cmp(14, 2);
    frame(1'b1, 1'b1, 7'h38, 16'h200f, 1, 1'b0);
    rchk(15, 1);
    shdn = 1'b1;
    wq = {8'h77, 8'h88};
    frame(1'b0, 1'b0, 7'h38, 16'h200f, 2, 1'b0);
    ex[15] = 8'h77;
    ex[16] = 8'h88;
    cmp(15, 2);
    for (int s = 0; s < 5; s++) begin
      do_reset(strap_t'(s));
      wq = {8'(8'hc0 + s)};
      frame(1'b0, 1'b0, 7'h38 + 7'(s & 3), 16'h2020 + 16'(s), 1, s == 4);
      if (s < 4) ex[32 + s] = 8'(8'hc0 + s);
      cmp(32, 5);
    end
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: logic/bit_sync.sv */
// two flip-flop synchroniser for level signals
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_t;
  sync_t s_r, s_nxt;
  always_comb begin
    s_nxt.meta = i_d;
    s_nxt.q = s_r.meta;
  end
  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end
  assign o_q = s_r.q;
endmodule
`default_nettype wire

/* File: logic/regi2c_pkg.sv */
// shared constants and types for the two-wire register access link
package regi2c_pkg;
  typedef logic [2:0] strap_t;
  typedef logic [15:0] ptr_t;
  localparam logic [6:0] TGT_ADDR_BASE = 7'h38;
  localparam strap_t STRAP_VDD = 3'h0;
  localparam strap_t STRAP_GND = 3'h1;
  localparam strap_t STRAP_SDA = 3'h2;
  localparam strap_t STRAP_SCL = 3'h3;
  localparam strap_t STRAP_OPEN = 3'h4;
  localparam ptr_t PTR_BASE = 16'h2000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_MIN_PERIOD_NS = 1000;
  localparam int QTR_CYC = (SCL_MIN_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);
  localparam logic [1:0] MAX_TRIES = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b011,
    ST_TX = 3'b010,
    ST_MACK = 3'b110,
    ST_SKIP = 3'b111
  } dev_st_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BYTE = 2'b11,
    H_STOP = 2'b10
  } host_st_t;
  typedef enum logic [2:0] {
    P_AW = 3'h0,
    P_PH = 3'h1,
    P_PL = 3'h2,
    P_WD = 3'h3,
    P_AR = 3'h4,
    P_RD = 3'h5
  } phase_t;
endpackage

/* File: logic/twi_host.sv */
// bus master end: makes the serial clock and runs register frames
`timescale 1ns/1ps
`default_nettype none
module twi_host (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_GO,
  input wire logic I_RD,
  input wire logic I_USE_PTR,
  input wire logic [6:0] I_DEV_ADDR,
  input wire regi2c_pkg::ptr_t I_PTR,
  input wire logic [7:0] I_LEN,
  input wire logic [7:0] I_WDATA,
  output logic O_WD_TAKE,
  output logic O_RD_VALID,
  output logic [7:0] O_RDATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_FAIL,
  twi_if.host TWI
);
  import regi2c_pkg::*;

  typedef struct packed {
    host_st_t st;
    phase_t ph;
    logic [3:0] qc;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] tries;
    logic [7:0] left;
    logic rd;
    logic useptr;
    logic [6:0] dev;
    ptr_t ptr;
    logic scl_oe;
    logic sda_oe;
    logic nack;
    logic again;
    logic fail;
    logic busy;
    logic done;
    logic take;
    logic rv;
    logic [7:0] rdata;
  } host_t;

  host_t hr, hn;
  logic sda_s;

  bit_sync #(.W(1)) u_sda (.i_clk(I_CLK), .i_d(TWI.sda), .o_q(sda_s));

  always_comb begin
    logic tick;
    logic [7:0] nb;
    logic [7:0] cur;
    tick = (hr.qc == QTR_LAST);
    nb = 8'hff;
    case (hr.ph)
      P_AW: nb = {hr.dev, 1'b0};
      P_AR: nb = {hr.dev, 1'b1};
      P_PH: nb = hr.ptr[15:8];
      P_PL: nb = hr.ptr[7:0];
      P_WD: nb = I_WDATA;
      default: nb = 8'hff;
    endcase
    cur = (hr.bitn == 4'h0) ? nb : hr.sh;
    hn = hr;
    hn.take = 1'b0;
    hn.rv = 1'b0;
    hn.done = 1'b0;
    hn.qc = tick ? 4'h0 : hr.qc + 4'h1;
    if (I_RST) begin
      hn = '0;
    end else if (hr.st == H_IDLE) begin
      hn.qc = 4'h0;
      hn.q = 2'h0;
      if (I_GO) begin
        hn.st = H_START;
        hn.busy = 1'b1;
        hn.fail = 1'b0;
        hn.tries = 2'h0;
        hn.rd = I_RD;
        hn.useptr = I_USE_PTR;
        hn.dev = I_DEV_ADDR;
        hn.ptr = I_PTR;
        hn.left = I_LEN;
        hn.ph = (I_RD & ~I_USE_PTR) ? P_AR : P_AW;
      end
    end else if (tick) begin
      hn.q = hr.q + 2'h1;
      case (hr.st)
        H_START: begin
          case (hr.q)
            2'h0: hn.sda_oe = 1'b0;
            2'h1: hn.scl_oe = 1'b0;
            2'h2: hn.sda_oe = 1'b1;
            default: begin
              hn.scl_oe = 1'b1;
              hn.st = H_BYTE;
              hn.bitn = 4'h0;
            end
          endcase
        end
        H_BYTE: begin
          case (hr.q)
            2'h0: begin
              hn.sh = cur;
              hn.take = (hr.bitn == 4'h0) && (hr.ph == P_WD);
              if (hr.bitn == BYTE_BITS) begin
                hn.sda_oe = (hr.ph == P_RD) && (hr.left != 8'h1);
              end else begin
                hn.sda_oe = (hr.ph != P_RD) && !cur[7];
              end
            end
            2'h1: hn.scl_oe = 1'b0;
            2'h2: begin
              if (hr.bitn == BYTE_BITS) begin
                hn.nack = sda_s;
              end else begin
                hn.sh = {hr.sh[6:0], (hr.ph == P_RD) ? sda_s : 1'b0};
              end
            end
            default: begin
              hn.scl_oe = 1'b1;
              hn.bitn = hr.bitn + 4'h1;
              if (hr.bitn == BYTE_BITS) begin
                hn.bitn = 4'h0;
                if (hr.ph == P_RD) begin
                  hn.rv = 1'b1;
                  hn.rdata = hr.sh;
                  hn.left = hr.left - 8'h1;
                  if (hr.left == 8'h1) hn.st = H_STOP;
                end else if (hr.nack) begin
                  hn.st = H_STOP;
                  hn.again = ((hr.ph == P_AW) || (hr.ph == P_AR)) && (hr.tries != MAX_TRIES);
                  hn.fail = ~hn.again;
                end else begin
                  case (hr.ph)
                    P_AW: hn.ph = P_PH;
                    P_PH: hn.ph = P_PL;
                    P_PL: begin
                      if (hr.rd) begin
                        hn.ph = P_AR;
                        hn.st = H_START;
                      end else begin
                        hn.ph = P_WD;
                      end
                    end
                    P_AR: hn.ph = P_RD;
                    default: begin
                      hn.left = hr.left - 8'h1;
                      if (hr.left == 8'h1) hn.st = H_STOP;
                    end
                  endcase
                end
              end
            end
          endcase
        end
        default: begin
          case (hr.q)
            2'h0: hn.sda_oe = 1'b1;
            2'h1: hn.scl_oe = 1'b0;
            2'h2: hn.sda_oe = 1'b0;
            default: begin
              if (hr.again) begin
                hn.again = 1'b0;
                hn.tries = hr.tries + 2'h1;
                hn.st = H_START;
                hn.ph = (hr.rd & ~hr.useptr) ? P_AR : P_AW;
              end else begin
                hn.st = H_IDLE;
                hn.busy = 1'b0;
                hn.done = 1'b1;
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    hr <= hn;
  end

  assign TWI.host_scl_o = 1'b0;
  assign TWI.host_sda_o = 1'b0;
  assign TWI.host_scl_oe = hr.scl_oe;
  assign TWI.host_sda_oe = hr.sda_oe;
  assign O_WD_TAKE = hr.take;
  assign O_RD_VALID = hr.rv;
  assign O_RDATA = hr.rdata;
  assign O_BUSY = hr.busy;
  assign O_DONE = hr.done;
  assign O_FAIL = hr.fail;
endmodule
`default_nettype wire

/* File: logic/twi_if.sv */
// two-wire bus with pull-ups resolved from the open-drain enables
`timescale 1ns/1ps
`default_nettype none
interface twi_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host(input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

/* File: logic/twi_target.sv */
// target end: two-wire link on the link clock, register port on I_CLK
`timescale 1ns/1ps
`default_nettype none
module twi_target (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_LINK_CLK,
  input wire regi2c_pkg::strap_t I_ADDR_STRAP,
  input wire logic I_ADDR_LOCKED,
  input wire logic I_SW_SHDN,
  input wire logic [7:0] I_REG_RDATA,
  output logic O_REG_WR,
  output logic O_REG_RD,
  output regi2c_pkg::ptr_t O_REG_ADDR,
  output logic [7:0] O_REG_WDATA,
  output logic O_ACTIVE,
  twi_if.device TWI
);
  import regi2c_pkg::*;

  typedef struct packed {
    dev_st_t st;
    strap_t strap;
    logic act;
    logic scl_p;
    logic sda_p;
    logic hi_start;
    logic resta;
    logic rw;
    logic mack;
    logic busy;
    logic req_t;
    logic req_we;
    logic ack_p;
    logic sda_oe;
    logic [3:0] bitc;
    logic [1:0] bidx;
    logic [7:0] sh;
    logic [7:0] rdbuf;
    logic [7:0] req_wd;
    ptr_t ptr;
    ptr_t req_a;
  } lnk_t;

  typedef struct packed {
    logic req_p;
    logic ack_t;
    logic [1:0] step;
    logic we;
    logic wr;
    logic rd;
    ptr_t addr;
    logic [7:0] wd;
    logic [7:0] rdata;
  } usr_t;

  lnk_t lr, ln;
  usr_t ur, un;
  logic [6:0] ls;
  logic [2:0] us;

  // hands one register access to the user domain
  function automatic lnk_t post(lnk_t s, logic we, ptr_t a, logic [7:0] d);
    lnk_t r;
    r = s;
    r.req_t = ~s.req_t;
    r.req_we = we;
    r.req_a = a;
    r.req_wd = d;
    r.busy = 1'b1;
    return r;
  endfunction

  // reset, ack toggle, strap, clock and data into the link domain
  bit_sync #(.W(7)) u_lsync (
    .i_clk(I_LINK_CLK),
    .i_d({I_RST, ur.ack_t, I_ADDR_STRAP, TWI.scl, TWI.sda}),
    .o_q(ls)
  );

  // link reset, request toggle and activity into the user domain
  bit_sync #(.W(3)) u_usync (
    .i_clk(I_CLK),
    .i_d({ls[6], lr.req_t, lr.act}),
    .o_q(us)
  );

  // link side
  always_comb begin
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic load;
    logic [6:0] me;
    scl = ls[1];
    sda = ls[0];
    rise = scl & ~lr.scl_p;
    fall = ~scl & lr.scl_p;
    start = scl & lr.scl_p & lr.sda_p & ~sda;
    stop = scl & lr.scl_p & ~lr.sda_p & sda;
    load = 1'b0;
    me = {TGT_ADDR_BASE[6:2], lr.strap[1:0]};
    ln = lr;
    ln.scl_p = scl;
    ln.sda_p = sda;
    ln.ack_p = ls[5];
    ln.act = (lr.st != ST_IDLE);
    if (ls[5] != lr.ack_p) begin
      ln.busy = 1'b0;
      ln.rdbuf = ur.rdata;
    end
    if (fall) ln.hi_start = 1'b0;
    if (ls[6]) begin
      ln = '0;
      ln.strap = ls[4:2];
      ln.scl_p = 1'b1;
      ln.sda_p = 1'b1;
      ln.ack_p = ls[5];
    end else if (lr.strap >= STRAP_OPEN) begin
      ln.st = ST_IDLE;
      ln.sda_oe = 1'b0;
    end else if (start) begin
      ln.st = ST_RX;
      ln.resta = (lr.st != ST_IDLE);
      ln.hi_start = 1'b1;
      ln.bitc = 4'h0;
      ln.bidx = 2'h0;
      ln.sda_oe = 1'b0;
    end else if (stop && !lr.hi_start) begin
      ln.st = ST_IDLE;
      ln.sda_oe = 1'b0;
    end else begin
      case (lr.st)
        ST_RX: begin
          if (rise) begin
            ln.sh = {lr.sh[6:0], sda};
            ln.bitc = lr.bitc + 4'h1;
          end
          if (fall && lr.bitc == BYTE_BITS) begin
            ln.st = ST_ACK;
            ln.sda_oe = 1'b1;
            ln.bitc = 4'h0;
            if (lr.bidx != 2'h3) ln.bidx = lr.bidx + 2'h1;
            case (lr.bidx)
              2'h0: begin
                if (lr.sh[7:1] != me || lr.busy) begin
                  ln.st = ST_SKIP;
                  ln.sda_oe = 1'b0;
                end else begin
                  ln.rw = lr.sh[0];
                  if (lr.sh[0]) begin
                    if (!lr.resta) ln.ptr = PTR_BASE;
                    ln = post(ln, 1'b0, ln.ptr, 8'h00);
                  end
                end
              end
              2'h1: ln.ptr[15:8] = lr.sh;
              2'h2: ln.ptr[7:0] = lr.sh;
              default: begin
                if (lr.busy) begin
                  ln.st = ST_SKIP;
                  ln.sda_oe = 1'b0;
                end else begin
                  ln = post(ln, 1'b1, lr.ptr, lr.sh);
                  ln.ptr = lr.ptr + 16'h1;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (fall) begin
            ln.sda_oe = 1'b0;
            ln.bitc = 4'h0;
            if (lr.rw) begin
              load = 1'b1;
            end else begin
              ln.st = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (lr.bitc == 4'h7) begin
              ln.st = ST_MACK;
              ln.sda_oe = 1'b0;
            end else begin
              ln.sh = {lr.sh[6:0], 1'b0};
              ln.sda_oe = ~lr.sh[6];
              ln.bitc = lr.bitc + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (rise) ln.mack = ~sda;
          if (fall) begin
            if (lr.mack) begin
              load = 1'b1;
            end else begin
              ln.st = ST_SKIP;
            end
          end
        end
        default: begin
          ln.sda_oe = 1'b0;
        end
      endcase
      if (load) begin
        ln.st = ST_TX;
        ln.bitc = 4'h0;
        ln.sh = lr.rdbuf;
        ln.sda_oe = ~lr.rdbuf[7];
        ln.ptr = lr.ptr + 16'h1;
        ln = post(ln, 1'b0, lr.ptr + 16'h1, 8'h00);
      end
    end
  end

  // user side: request fields are held by the link side until the ack toggle
  always_comb begin
    un = ur;
    un.wr = 1'b0;
    un.rd = 1'b0;
    // held in reset until the link side has left its own reset
    if (I_RST || us[2]) begin
      un = '0;
      un.req_p = us[1];
    end else begin
      case (ur.step)
        2'h0: begin
          if (us[1] != ur.req_p) begin
            un.req_p = us[1];
            un.we = lr.req_we;
            un.addr = lr.req_a;
            un.wd = lr.req_wd;
            un.step = 2'h1;
          end
        end
        2'h1: begin
          un.wr = ur.we & (I_SW_SHDN | ~I_ADDR_LOCKED);
          un.rd = ~ur.we;
          un.step = 2'h2;
        end
        2'h2: un.step = 2'h3;
        default: begin
          if (!ur.we) un.rdata = I_REG_RDATA;
          un.ack_t = ~ur.ack_t;
          un.step = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge I_LINK_CLK) begin
    lr <= ln;
  end

  always_ff @(posedge I_CLK) begin
    ur <= un;
  end

  assign TWI.dev_sda_o = 1'b0;
  assign TWI.dev_sda_oe = lr.sda_oe;
  assign O_REG_WR = ur.wr;
  assign O_REG_RD = ur.rd;
  assign O_REG_ADDR = ur.addr;
  assign O_REG_WDATA = ur.wd;
  assign O_ACTIVE = us[0];
endmodule
`default_nettype wire
